// >>> rmpc_pkg.sv
// Shared constants and types for the retimer management pin control block
package rmpc_pkg;

    // Channel count and strap width
    localparam int NUM_CH             = 4;
    localparam int ADDR_W             = 4;

    // Clock periods of the two domains
    localparam int CLK_SYS_PERIOD_NS  = 8;
    localparam int LINK_CLK_PERIOD_NS = 30;

    // Strap settle time after reset release, before the straps are sampled
    localparam int STRAP_SETTLE_NS    = 200;
    localparam int STRAP_SETTLE_CYC   =
        (STRAP_SETTLE_NS + CLK_SYS_PERIOD_NS - 1) / CLK_SYS_PERIOD_NS;

    // Quarter period of the controller-mode serial clock (100 kHz bus)
    localparam int SCL_QTR_NS         = 2500;
    localparam int SCL_QTR_CYC        =
        (SCL_QTR_NS + LINK_CLK_PERIOD_NS - 1) / LINK_CLK_PERIOD_NS;

    // Configuration memory access
    localparam logic [6:0] EE_DEV_ADDR  = 7'h50;
    localparam int         EE_NUM_BYTES = 4;
    localparam int         CFG_W        = 8 * EE_NUM_BYTES;

    // Reset values
    localparam logic [ADDR_W-1:0] ADDR_RESET      = 4'h0;
    localparam logic              LOAD_DONE_RESET = 1'b1;

    // Controller-mode load sequencer states
    typedef enum logic [2:0] {
        EE_IDLE,
        EE_START,
        EE_ADDR,
        EE_READ,
        EE_STOP
    } rmpc_ee_state_t;

endpackage

// >>> rmpc_ee_loader.sv
// Controller-mode configuration reader on the link clock domain
`timescale 1ns/1ns
`default_nettype none
module rmpc_ee_loader
    import rmpc_pkg::*;
(
    input  wire logic             link_clk,   // Link-side clock
    input  wire logic             reset_n,    // Async reset, active low
    input  wire logic             start_tgl,  // Load request toggle from clk_sys
    output logic                  done_tgl,   // Load finished toggle
    output logic                  ack_error,  // Memory did not acknowledge
    output logic [CFG_W-1:0]      cfg_image,  // Bytes read, first in low byte
    input  wire logic             scl_in,     // Serial clock pin level
    output logic                  scl_out,    // Serial clock drive value
    output logic                  scl_oe,     // Serial clock pull-low enable
    input  wire logic             sda_in,     // Serial data pin level
    output logic                  sda_out,    // Serial data drive value
    output logic                  sda_oe      // Serial data pull-low enable
);

    logic [1:0]     rst_pipe;   // Local reset release synchroniser
    logic           link_rst_n; // Reset released on link clock
    logic [2:0]     st_sync;    // Start toggle synchroniser plus history
    logic [1:0]     scl_sync;   // Clock pin synchroniser
    logic [1:0]     sda_sync;   // Data pin synchroniser
    logic           start_req;  // One-cycle start request
    rmpc_ee_state_t state;      // Sequencer state
    logic [7:0]     qcnt;       // Quarter period counter
    logic [1:0]     phase;      // Quarter within bit
    logic [3:0]     bit_idx;    // Bit within byte, 8 is acknowledge
    logic [1:0]     byte_idx;   // Byte being read
    logic [7:0]     shreg;      // Shift register
    logic           tick;       // End of quarter
    logic           stall;      // Clock held low by another party
    logic           next_scl_oe; // Clock pull-low for next cycle
    logic           next_sda_oe; // Data pull-low for next cycle

    // Release reset synchronously to the link clock
    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_pipe <= 2'b00;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign link_rst_n = rst_pipe[1];

    // Two-flop synchronisers for the toggle and both bus lines
    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            st_sync  <= 3'h0;
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
        end else begin
            st_sync  <= {st_sync[1:0], start_tgl};
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
        end
    end
    assign start_req = st_sync[2] ^ st_sync[1];

    // Quarter timing; high quarter waits for the clock to really rise
    assign stall = (state != EE_IDLE) && (phase == 2'd1) && !scl_sync[1];
    assign tick  = (qcnt == 8'(SCL_QTR_CYC - 1)) && !stall;

    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            qcnt  <= 8'h00;
            phase <= 2'd0;
        end else if (state == EE_IDLE) begin
            qcnt  <= 8'h00;
            phase <= 2'd0;
        end else if (tick) begin
            qcnt  <= 8'h00;
            phase <= phase + 2'd1;
        end else if (!stall) begin
            qcnt  <= qcnt + 8'h01;
        end
    end

    // Sequencer: start, address with read bit, bytes, stop
    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            state     <= EE_IDLE;
            bit_idx   <= 4'h0;
            byte_idx  <= 2'h0;
            done_tgl  <= 1'b0;
            ack_error <= 1'b0;
        end else begin
            unique case (state)
                EE_IDLE: begin
                    if (start_req) begin
                        state     <= EE_START;
                        ack_error <= 1'b0;
                        byte_idx  <= 2'h0;
                    end
                end
                EE_START: begin
                    bit_idx <= 4'h0;
                    if (tick && phase == 2'd3) begin
                        state <= EE_ADDR;
                    end
                end
                EE_ADDR: begin
                    // No acknowledge from the memory ends the load early
                    if (tick && phase == 2'd2 && bit_idx == 4'h8 && sda_sync[1]) begin
                        ack_error <= 1'b1;
                    end
                    if (tick && phase == 2'd3) begin
                        bit_idx <= (bit_idx == 4'h8) ? 4'h0 : bit_idx + 4'h1;
                        if (bit_idx == 4'h8) begin
                            state <= ack_error ? EE_STOP : EE_READ;
                        end
                    end
                end
                EE_READ: begin
                    if (tick && phase == 2'd3) begin
                        bit_idx <= (bit_idx == 4'h8) ? 4'h0 : bit_idx + 4'h1;
                        if (bit_idx == 4'h8) begin
                            byte_idx <= byte_idx + 2'h1;
                            if (byte_idx == 2'(EE_NUM_BYTES - 1)) begin
                                state <= EE_STOP;
                            end
                        end
                    end
                end
                EE_STOP: begin
                    // Bus released and completion handed back
                    if (tick && phase == 2'd3) begin
                        state    <= EE_IDLE;
                        done_tgl <= ~done_tgl;
                    end
                end
            endcase
        end
    end

    // Shift register: address out, data in, bytes stored in order
    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            shreg     <= 8'h00;
            cfg_image <= '0;
        end else if (state == EE_START) begin
            shreg <= {EE_DEV_ADDR, 1'b1};
        end else if (tick && phase == 2'd3 && state == EE_ADDR && bit_idx < 4'h8) begin
            shreg <= {shreg[6:0], 1'b0};
        end else if (tick && phase == 2'd2 && state == EE_READ) begin
            if (bit_idx < 4'h8) begin
                shreg <= {shreg[6:0], sda_sync[1]};
            end else begin
                cfg_image[byte_idx*8 +: 8] <= shreg;
            end
        end
    end

    // Open-drain drive decisions per state and quarter
    always_comb begin
        next_scl_oe = 1'b0;
        next_sda_oe = 1'b0;
        unique case (state)
            EE_IDLE: begin
                next_scl_oe = 1'b0;
                next_sda_oe = 1'b0;
            end
            EE_START: begin
                next_sda_oe = (phase != 2'd0);
                next_scl_oe = (phase == 2'd3);
            end
            EE_ADDR: begin
                next_scl_oe = (phase == 2'd0) || (phase == 2'd3);
                next_sda_oe = (bit_idx < 4'h8) && !shreg[7];
            end
            EE_READ: begin
                next_scl_oe = (phase == 2'd0) || (phase == 2'd3);
                next_sda_oe = (bit_idx == 4'h8) &&
                              (byte_idx != 2'(EE_NUM_BYTES - 1));
            end
            EE_STOP: begin
                next_scl_oe = (phase == 2'd0);
                next_sda_oe = (phase == 2'd0) || (phase == 2'd1);
            end
        endcase
    end

    // Pins only ever pull low; value fixed at zero
    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            scl_oe  <= 1'b0;
            sda_oe  <= 1'b0;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            scl_oe  <= next_scl_oe;
            sda_oe  <= next_sda_oe;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end
    end

    // Checks on the link side
    sda_open_drain_a: assert property (
        @(posedge link_clk) disable iff (!link_rst_n) !sda_out)
        else $error("data pin driven high");
    scl_open_drain_a: assert property (
        @(posedge link_clk) disable iff (!link_rst_n) !scl_out)
        else $error("clock pin driven high");
    bus_release_a: assert property (
        @(posedge link_clk) disable iff (!link_rst_n)
        (state == EE_STOP && tick && phase == 2'd3) |=> ##1 (!scl_oe && !sda_oe))
        else $error("bus not released after load");
    load_done_c: cover property (
        @(posedge link_clk) disable iff (!link_rst_n)
        (state == EE_STOP) ##1 (state == EE_IDLE));

endmodule
`default_nettype wire

// >>> rmpc_top.sv
// Management pin logic: role, straps, lock pins, alert, config load
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Lock pin high while channel recovery locked
// - Lock pins are straps sampled at startup
// - Controller mode: done pin low after load
// - Falling load trigger starts memory load
// - Alert on eye, signal or lock fault
// - Role input high target, floating controller
// - Data pin input, open-drain pull-low only
// - Reference input copied to buffered output
// - Straps set own address in target mode
// - Clock pin input, open-drain as controller
module rmpc_top
    import rmpc_pkg::*;
(
    input  wire logic              clk_sys,               // System clock, 125 MHz
    input  wire logic              reset_n,               // Async reset, active low
    input  wire logic              link_clk,              // Management link clock
    input  wire logic              bus_role_select,       // High target, float controller
    input  wire logic              load_trigger,          // Falling edge starts load
    output logic                   load_done_n,           // Low when load finished
    input  wire logic [NUM_CH-1:0] cdr_locked,            // Recovery lock per channel
    input  wire logic [NUM_CH-1:0] signal_detect,         // Input signal present
    input  wire logic [NUM_CH-1:0] eye_h_fault,           // Horizontal eye out of range
    input  wire logic [NUM_CH-1:0] eye_v_fault,           // Vertical eye out of range
    input  wire logic [NUM_CH-1:0] lock_pad_in,           // Lock pin level, strap value
    output logic [NUM_CH-1:0]      lock_pad_out,          // Lock pin drive value
    output logic [NUM_CH-1:0]      lock_pad_oe,           // Lock pin drive enable
    output logic [ADDR_W-1:0]      target_addr,           // Strapped bus address
    output logic                   is_target,             // Target role selected
    output logic                   load_error,            // Last load saw no acknowledge
    output logic [CFG_W-1:0]       cfg_image,             // Configuration read at load
    output logic                   alert_out,             // Alert drive value, always 0
    output logic                   alert_oe,              // Alert pull-low enable
    input  wire logic              ref_osc_in,            // Reference oscillator input
    output logic                   ref_osc_buffered_out,  // Buffered reference copy
    input  wire logic              mgmt_serial_clock_in,  // Serial clock pin level
    output logic                   mgmt_serial_clock_out, // Serial clock drive value
    output logic                   mgmt_serial_clock_oe,  // Serial clock pull-low
    input  wire logic              mgmt_data_in,          // Serial data pin level
    output logic                   mgmt_data_out,         // Serial data drive value
    output logic                   mgmt_data_oe           // Serial data pull-low
);

    localparam int AW = 4 + 5 * NUM_CH; // Width of synchronised input group

    logic [AW-1:0]        async_in;   // All inputs from outside clk_sys
    logic [AW-1:0]        sync_1;     // First synchroniser stage
    logic [AW-1:0]        sync_2;     // Second synchroniser stage
    logic                 trig_s;     // Synchronised load trigger
    logic                 trig_prev;  // Trigger one cycle earlier
    logic                 role_s;     // Synchronised role select
    logic                 ref_s;      // Synchronised reference
    logic                 done_s;     // Synchronised done toggle
    logic                 done_prev;  // Done toggle one cycle earlier
    logic [NUM_CH-1:0]    cdr_s;      // Synchronised lock states
    logic [NUM_CH-1:0]    sd_s;       // Synchronised signal detect
    logic [NUM_CH-1:0]    eh_s;       // Synchronised horizontal fault
    logic [NUM_CH-1:0]    ev_s;       // Synchronised vertical fault
    logic [NUM_CH-1:0]    pad_s;      // Synchronised strap levels
    logic                 done_tgl;   // Done toggle from link domain
    logic                 ee_error;   // Acknowledge failure from link domain
    logic [CFG_W-1:0]     ee_image;   // Image held stable in link domain
    logic                 start_tgl;  // Start toggle toward link domain
    logic                 busy;       // Load in progress
    logic                 strap_done; // Straps taken, lock pins driving
    logic [7:0]           settle_cnt; // Strap settle counter
    logic                 load_fire;  // Start a load this cycle
    logic                 done_pulse; // Load finished this cycle

    // Channel fault decode: eye out of range, signal lost or unlocked
    function automatic logic [NUM_CH-1:0] chan_fault(
        input logic [NUM_CH-1:0] lck,
        input logic [NUM_CH-1:0] sd,
        input logic [NUM_CH-1:0] eh,
        input logic [NUM_CH-1:0] ev
    );
        chan_fault = eh | ev | ~sd | ~lck;
    endfunction

    assign async_in = {done_tgl, load_trigger, bus_role_select, ref_osc_in,
                       cdr_locked, signal_detect, eye_h_fault, eye_v_fault, lock_pad_in};

    // Two-flop synchroniser for every asynchronous input
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sync_1 <= '0;
            sync_2 <= '0;
        end else begin
            sync_1 <= async_in;
            sync_2 <= sync_1;
        end
    end
    assign {done_s, trig_s, role_s, ref_s, cdr_s, sd_s, eh_s, ev_s, pad_s} = sync_2;

    // Edge history of trigger and done toggle
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            trig_prev <= 1'b0;
            done_prev <= 1'b0;
        end else begin
            trig_prev <= trig_s;
            done_prev <= done_s;
        end
    end
    assign done_pulse = done_s ^ done_prev;
    // Target mode ignores the trigger, which the board holds low there
    assign load_fire  = trig_prev && !trig_s && !role_s && !busy && strap_done;

    // Role follows the select pin: high target, floating reads low
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            is_target <= 1'b0;
        end else begin
            is_target <= role_s;
        end
    end

    // Strap settle, sample, then hand the pins over to lock indication
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            settle_cnt  <= 8'h00;
            strap_done  <= 1'b0;
            target_addr <= ADDR_RESET;
        end else if (!strap_done) begin
            if (settle_cnt == 8'(STRAP_SETTLE_CYC - 1)) begin
                strap_done  <= 1'b1;
                target_addr <= pad_s;
            end else begin
                settle_cnt <= settle_cnt + 8'h01;
            end
        end
    end

    // Lock pins drive the channel lock state once straps are taken
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_lock
        always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
                lock_pad_out[ch] <= 1'b0;
                lock_pad_oe[ch]  <= 1'b0;
            end else begin
                lock_pad_out[ch] <= strap_done && cdr_s[ch];
                lock_pad_oe[ch]  <= strap_done;
            end
        end
    end

    // Load request toggle, busy flag and completion pin
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            start_tgl   <= 1'b0;
            busy        <= 1'b0;
            load_done_n <= LOAD_DONE_RESET;
        end else if (load_fire) begin
            start_tgl   <= ~start_tgl;
            busy        <= 1'b1;
            load_done_n <= 1'b1;
        end else if (done_pulse) begin
            busy        <= 1'b0;
            load_done_n <= is_target;
        end
    end

    // Image and error are stable in the link domain once done toggles
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cfg_image  <= '0;
            load_error <= 1'b0;
        end else if (done_pulse) begin
            cfg_image  <= ee_image;
            load_error <= ee_error;
        end
    end

    // Alert pulls low while any channel reports a fault
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            alert_oe  <= 1'b0;
            alert_out <= 1'b0;
        end else begin
            alert_oe  <= |chan_fault(cdr_s, sd_s, eh_s, ev_s);
            alert_out <= 1'b0;
        end
    end

    // Buffered copy of the reference oscillator
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ref_osc_buffered_out <= 1'b0;
        end else begin
            ref_osc_buffered_out <= ref_s;
        end
    end

    // Controller-mode reader on the link clock
    rmpc_ee_loader u_loader (
        .link_clk  (link_clk),
        .reset_n   (reset_n),
        .start_tgl (start_tgl),
        .done_tgl  (done_tgl),
        .ack_error (ee_error),
        .cfg_image (ee_image),
        .scl_in    (mgmt_serial_clock_in),
        .scl_out   (mgmt_serial_clock_out),
        .scl_oe    (mgmt_serial_clock_oe),
        .sda_in    (mgmt_data_in),
        .sda_out   (mgmt_data_out),
        .sda_oe    (mgmt_data_oe)
    );

    // Checks on the system side
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    lock_follow_a: assert property (
        strap_done |=> (lock_pad_out == $past(cdr_s)))
        else $error("lock pin does not follow lock state");
    strap_hiz_a: assert property (
        !strap_done |=> (lock_pad_oe == '0 || $past(settle_cnt) == 8'(STRAP_SETTLE_CYC - 1)))
        else $error("lock pin driven before straps taken");
    strap_addr_a: assert property (
        $rose(strap_done) |-> (target_addr == $past(pad_s)) ##1 $stable(target_addr))
        else $error("address not taken from straps");
    done_low_a: assert property (
        (done_pulse && !is_target && !load_fire) |=> !load_done_n)
        else $error("done pin not low after load");
    load_start_a: assert property (
        load_fire |=> (busy && load_done_n && start_tgl != $past(start_tgl)))
        else $error("falling trigger did not start load");
    target_no_load_a: assert property (
        role_s |=> $stable(start_tgl))
        else $error("load started in target role");
    alert_fault_a: assert property (
        (|chan_fault(cdr_s, sd_s, eh_s, ev_s)) |=> alert_oe && !alert_out)
        else $error("alert missing on channel fault");
    role_sel_a: assert property (
        $rose(role_s) |=> is_target)
        else $error("role not taken from select pin");
    ref_copy_a: assert property (
        ##1 ref_osc_buffered_out == $past(ref_s))
        else $error("reference copy wrong");

    strap_taken_c: cover property ($rose(strap_done));
    load_cycle_c: cover property ($fell(load_done_n));
    alert_rise_c: cover property ($rose(alert_oe));

endmodule
`default_nettype wire

// >>> rmpc_mem_model.sv
// Behavioural configuration memory on the management serial bus
`timescale 1ns/1ns
`default_nettype none
module rmpc_mem_model
    import rmpc_pkg::*;
#(
    parameter logic [CFG_W-1:0] IMAGE = 32'h7e813ca5  // Bytes served, byte 0 low
)(
    input  wire logic scl,     // Resolved serial clock line
    input  wire logic sda,     // Resolved serial data line
    input  wire logic ack_en,  // Low makes the memory ignore its address
    output logic      sda_oe   // High pulls the data line low
);
    int         n = 99;        // Clock rises since start, 99 when idle
    logic [7:0] addr = 8'h00;  // Address byte shifted in
    logic       ok = 1'b0;     // Address matched and acknowledged
    logic       scl_q = 1'b1;  // Clock level seen last
    logic       sda_q = 1'b1;  // Data level seen last
    // One process watches both lines, so every model variable has one writer
    initial begin
        sda_oe = 1'b0;
        forever begin
            @(scl or sda);
            if (scl_q === 1'b1 && scl === 1'b1 && sda !== sda_q) begin
                // Data moves while clock is high: fall is start, rise is stop
                n = (sda === 1'b0) ? 0 : 99;
                ok = 1'b0;
                sda_oe = 1'b0;
            end else if (scl_q !== 1'b1 && scl === 1'b1) begin
                // Bits are sampled on the rising clock
                if (n < 8) addr = {addr[6:0], sda};
                if (n < 99) n = n + 1;
            end else if (scl_q === 1'b1 && scl !== 1'b1) begin
                // Drive only while clock is low: acknowledge, then data MSB first
                if (n == 8) begin
                    ok = ack_en && (addr == {EE_DEV_ADDR, 1'b1});
                    sda_oe = ok;
                end else if (ok && n >= 9 && n < 45 && (n - 9) % 9 < 8) begin
                    sda_oe = ~IMAGE[8 * ((n - 9) / 9) + 7 - (n - 9) % 9];
                end else begin
                    sda_oe = 1'b0;  // Released: pull-up takes the line high
                end
            end
            scl_q = scl;
            sda_q = sda;
        end
    end
endmodule
`default_nettype wire

// >>> retimer_mgmt_pin_control_bench.sv
// Self-checking bench for the management pin control block
`timescale 1ns/1ns
`default_nettype none
module retimer_mgmt_pin_control_bench;
    import rmpc_pkg::*;
    logic        clk_sys = 1'b0, reset_n = 1'b0, link_clk = 1'b0;
    logic        role = 1'b0, trig = 1'b0, ref_in = 1'b0;
    logic        ack_en = 1'b1;                       // Memory answers its address
    logic [3:0]  lck = 4'hf, sd = 4'hf, eh = 4'h0, ev = 4'h0, strap = 4'ha;
    wire  [3:0]  pad_out, pad_oe, tgt;
    wire  [31:0] cfg;
    wire         done_n, is_t, lerr, al_o, al_oe, ref_o, scl_o, scl_oe, sda_o, sda_oe, mem_oe;
    wire  [3:0]  pad = (pad_oe & pad_out) | (~pad_oe & strap);  // Strap until driven
    wire         scl = ~scl_oe;                                  // Pull-up lines
    wire         sda = ~(sda_oe | mem_oe);
    int          failures = 0, checks_done = 0, cycles = 0;
    rmpc_top u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .link_clk(link_clk),
        .bus_role_select(role), .load_trigger(trig), .load_done_n(done_n), .cdr_locked(lck),
        .signal_detect(sd), .eye_h_fault(eh), .eye_v_fault(ev), .lock_pad_in(pad),
        .lock_pad_out(pad_out), .lock_pad_oe(pad_oe), .target_addr(tgt), .is_target(is_t),
        .load_error(lerr), .cfg_image(cfg), .alert_out(al_o), .alert_oe(al_oe),
        .ref_osc_in(ref_in), .ref_osc_buffered_out(ref_o), .mgmt_serial_clock_in(scl),
        .mgmt_serial_clock_out(scl_o), .mgmt_serial_clock_oe(scl_oe), .mgmt_data_in(sda),
        .mgmt_data_out(sda_o), .mgmt_data_oe(sda_oe));
    rmpc_mem_model u_mem (.scl(scl), .sda(sda), .ack_en(ack_en), .sda_oe(mem_oe));
    // Clocks: 8 ns system, 30 ns link with its own phase
    initial forever #4 clk_sys = ~clk_sys;
    initial begin
        #7;
        forever #15 link_clk = ~link_clk;
    end
    // Hang guard: two loads take about 74000 cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 95000) begin
            failures++;
            end_sim();
        end
    end
    task cyc(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task end_sim;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Straps taken once, later pin changes ignored
    task t_straps;
        cyc(30);
        chk("target_addr", 32'ha, tgt);
        chk("lock_pad_oe", 32'hf, pad_oe);
        strap = 4'h5;
        cyc(5);
        chk("target_addr_held", 32'ha, tgt);
    endtask
    // Lock pins follow recovery lock; unlock also raises alert
    task t_lock;
        lck = 4'h6;
        cyc(4);
        chk("lock_pad_out", 32'h6, pad_out);
        chk("alert_unlock", 32'h1, al_oe);
        lck = 4'hf;
        cyc(4);
        chk("lock_pad_out_all", 32'hf, pad_out);
    endtask
    // Each eye and signal alert cause in turn, then cleared; drive value stays low
    task t_alert;
        for (int i = 0; i < 3; i++) begin
            eh = (i == 0) ? 4'h2 : 4'h0;
            ev = (i == 1) ? 4'h4 : 4'h0;
            sd = (i == 2) ? 4'he : 4'hf;
            cyc(4);
            chk("alert_oe", 32'h1, al_oe);
            chk("alert_out", 32'h0, al_o);
            {eh, ev, sd} = {4'h0, 4'h0, 4'hf};
            cyc(4);
            chk("alert_clear", 32'h0, al_oe);
        end
    endtask
    task t_ref;
        // 25 MHz source first: 24 ns high, 16 ns low
        repeat (4) begin
            ref_in = 1'b1;
            cyc(3);
            chk("ref_out_run", 32'h1, ref_o);
            ref_in = 1'b0;
            cyc(2);
        end
        ref_in = 1'b1;
        cyc(4);
        chk("ref_out_high", 32'h1, ref_o);
        ref_in = 1'b0;
        cyc(4);
        chk("ref_out_low", 32'h0, ref_o);
    endtask
    // Falling trigger runs a load; lines released and done low after it
    task t_load(input logic ack, input logic err);
        int k;
        logic seen;
        ack_en = ack;
        seen = 1'b0;
        trig = 1'b1;
        cyc(4);
        trig = 1'b0;
        cyc(6);
        chk("done_n_busy", 32'h1, done_n);
        for (k = 0; k < 70000 && done_n !== 1'b0; k++) begin
            cyc(1);
            seen |= (scl_oe === 1'b1);
        end
        chk("scl_driven", 32'h1, seen);
        chk("done_n", 32'h0, done_n);
        chk("load_error", err, lerr);
        if (ack) chk("cfg_image", 32'h7e813ca5, cfg);
        cyc(100);
        chk("lines_free", 32'h0, {scl_oe, sda_oe, scl_o, sda_o});
    endtask
    // Target role: trigger held low, bus untouched
    task t_target;
        role = 1'b1;
        trig = 1'b0;
        cyc(400);
        chk("is_target", 32'h1, is_t);
        chk("lines_idle", 32'h0, {scl_oe, sda_oe});
    endtask
    initial begin
        cyc(10);
        reset_n = 1'b1;
        t_straps();
        chk("is_target_low", 32'h0, is_t);
        t_lock();
        t_alert();
        t_ref();
        t_load(1'b1, 1'b0);
        t_load(1'b0, 1'b1);
        t_target();
        end_sim();
    end
endmodule
`default_nettype wire
